// file: pccb_pkg.sv
// Shared constants for the clock configuration bank: offsets, fields, codes.
// Assumes one 50 MHz clock and the byte-wide register port of the device.
package pccb_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] ADDR_CLK_GATING = 16'h0000; // Clock gating register
    localparam logic [15:0] ADDR_PLL_DEN_HI = 16'h0001; // Denominator upper byte
    localparam logic [15:0] ADDR_PLL_DEN_LO = 16'h0002; // Denominator lower byte
    localparam logic [15:0] ADDR_PLL_NUM_HI = 16'h0003; // Numerator upper byte
    localparam logic [15:0] ADDR_PLL_NUM_LO = 16'h0004; // Numerator lower byte
    localparam logic [15:0] ADDR_PLL_INT = 16'h0005; // Integer/divider/type
    localparam logic [15:0] ADDR_PLL_LOCK = 16'h0006; // Lock flag, read only
    localparam logic [15:0] ADDR_OUT_CLK = 16'h0007; // Output clock select
    localparam logic [15:0] ADDR_LDO = 16'h0008; // Regulator control
    localparam logic [15:0] ADDR_PARAM_BASE = 16'h4000; // First parameter address
    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_MAIN_GATE = 0; // Main clock gate
    localparam int BIT_HALVER = 1; // Master clock divider
    localparam int BIT_SRC_SEL = 3; // Main clock source
    localparam int BIT_PLL_POWER = 7; // PLL power enable
    localparam int BIT_PLL_FRAC = 0; // Integer or fractional
    localparam int BIT_PREDIV_LO = 1; // Predivider field low bit
    localparam int BIT_MULT_LO = 3; // Multiplier field low bit
    localparam int BIT_LDO_SHUTDOWN = 2; // Regulator power down
    localparam int BIT_LDO_VSEL_LO = 0; // Voltage select low bit
    localparam int W_MULT = 4; // Multiplier width
    localparam int W_PREDIV = 2; // Predivider width
    localparam int W_VSEL = 2; // Voltage select width
    localparam int W_FREQ = 3; // Output clock code width
    localparam int W_PDM = 2; // PDM output config width
    // Writable bits of the clock gating register
    localparam logic [7:0] CLK_GATING_MASK = 8'h8f;
    localparam logic [7:0] RESET_BYTE = 8'h00; // All registers reset to zero
    // ****************************************
    // Output clock codes
    // ****************************************
    localparam logic [2:0] FREQ_DOUBLE = 3'h0; // Fastest setting
    localparam logic [2:0] FREQ_PASS = 3'h1; // Undivided
    localparam logic [2:0] FREQ_HALF = 3'h2; // Divide by 2
    localparam logic [2:0] FREQ_QUARTER = 3'h3; // Divide by 4
    localparam logic [2:0] FREQ_EIGHTH = 3'h4; // Divide by 8
    localparam logic [2:0] FREQ_OFF = 3'h7; // Output off
    // Toggle-interval masks for the aux clock divider
    localparam logic [4:0] MASK_DOUBLE = 5'h00;
    localparam logic [4:0] MASK_PASS = 5'h01;
    localparam logic [4:0] MASK_HALF = 5'h03;
    localparam logic [4:0] MASK_QUARTER = 5'h07;
    localparam logic [4:0] MASK_EIGHTH = 5'h0f;
endpackage

// file: pccb_aux_clock_pin_if.sv
// Carrier between the register bank and the aux clock generator.
// Assumes both ends sit on the same clock.
interface pccb_aux_clock_pin_if;
    logic [2:0] freq_code; // Output clock code
    logic pdm_on; // PDM output path enabled
    logic pin_clk_mode; // Shared pin set to clock output
    logic aux_clk; // Generated aux clock level
    modport bank (output freq_code, output pdm_on, output pin_clk_mode, input aux_clk);
    modport gen (input freq_code, input pdm_on, input pin_clk_mode, output aux_clk);
endinterface

// file: pccb_aux_clock.sv
// Aux clock generator: divides the system clock by the selected code.
// Assumes settings arrive on the same clock from the register bank.
module pccb_aux_clock (
    input wire logic clock,
    input wire logic rst_n,
    pccb_aux_clock_pin_if.gen co
);
    import pccb_pkg::*;

    // ****************************************
    // Divider selection
    // ****************************************
    logic [4:0] div_cnt_reg; // Free-running divider count
    logic aux_reg; // Toggling output level
    logic [4:0] tick_mask; // Interval mask for the current code
    logic code_valid; // Code selects a running clock
    logic run; // Output allowed to toggle
    logic tick; // Toggle point

    // Five codes run; reserved codes behave as off
    assign tick_mask = (co.freq_code == FREQ_DOUBLE) ? MASK_DOUBLE :
                       (co.freq_code == FREQ_PASS) ? MASK_PASS :
                       (co.freq_code == FREQ_HALF) ? MASK_HALF :
                       (co.freq_code == FREQ_QUARTER) ? MASK_QUARTER : MASK_EIGHTH;
    assign code_valid = (co.freq_code <= FREQ_EIGHTH);
    assign run = code_valid && co.pin_clk_mode &&
                 !(co.pdm_on && (co.freq_code == FREQ_DOUBLE || co.freq_code == FREQ_PASS));
    assign tick = ((div_cnt_reg & tick_mask) == tick_mask);

    // Counter and output flop; output parks low when stopped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_reg <= 5'h00;
            aux_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
            aux_reg <= run ? (aux_reg ^ tick) : 1'b0;
        end
    end
    assign co.aux_clk = aux_reg;

    // ****************************************
    // Checks
    // ****************************************
    chk_aux_off_code: assert property (@(posedge clock) disable iff (!rst_n)
        (co.freq_code == FREQ_OFF) |=> !aux_reg) else $error("aux clock runs while off");
    chk_aux_pdm_block: assert property (@(posedge clock) disable iff (!rst_n)
        (co.pdm_on && co.freq_code == FREQ_PASS) |=> !aux_reg) else $error("fast clock with PDM");
    chk_aux_pin_mode: assert property (@(posedge clock) disable iff (!rst_n)
        !co.pin_clk_mode |=> !aux_reg) else $error("aux clock outside pin mode");
    chk_aux_double_run: assert property (@(posedge clock) disable iff (!rst_n)
        (run && co.freq_code == FREQ_DOUBLE) ##1 (run && co.freq_code == FREQ_DOUBLE)
        |=> (aux_reg != $past(aux_reg))) else $error("fastest clock not toggling");
endmodule

// file: pccb_clock_bank.sv
// Clock configuration bank: clock gating, PLL settings, lock flag,
// aux clock select and regulator control, behind the byte register port.
// Assumes the control interface decoder presents one-cycle read/write strobes.
// ****************************************
// Rule summary
// ****************************************
// Contract
// - Gate off: only gating and PLL writes
// - Main gate also gates PLL clock
// - Parameters locked until DSP clock enabled
// - Main gate bit 0, reset 0
// - Denominator bytes at 0x0001, 0x0002
// - Numerator bytes at 0x0003, 0x0004
// - Multiplier bits 6:3, type bit 0
// - Predivider bits 2:1, divide 1..4
// - Read-only lock flag at 0x0006
// - Three-bit aux clock frequency code
// - Fast aux settings dead under PDM
// - Aux select only in pin clock mode
// - Regulator bit 2 powers LDO down
// - Regulator bits 1:0 pick voltage
// - Bit 7 powers the PLL
// - PLL clock needs power and gate
// - Source select: pin or PLL
// - Master clock halver bit
module pccb_clock_bank #(
    parameter logic [15:0] PARAM_BASE_ADDR = pccb_pkg::ADDR_PARAM_BASE
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic REG_WR_EN,
    input wire logic REG_RD_EN,
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic PLL_LOCK_IN,
    input wire logic DSP_CLK_EN,
    input wire logic [pccb_pkg::W_PDM-1:0] PDM_OUTPUT_CONFIG_CFG,
    input wire logic PIN_CLK_MODE,
    output logic [7:0] REG_RDATA,
    output logic REG_RD_VALID,
    output logic REG_FWD_WE,
    output logic [15:0] REG_FWD_ADDR,
    output logic [7:0] REG_FWD_WDATA,
    output logic MAIN_CLK_EN,
    output logic MAIN_CLK_SRC,
    output logic MCLK_HALVE,
    output logic PLL_POWER,
    output logic PLL_CLK_EN,
    output logic [15:0] PLL_DEN,
    output logic [15:0] PLL_NUM,
    output logic [pccb_pkg::W_MULT-1:0] PLL_MULT,
    output logic [pccb_pkg::W_PREDIV-1:0] PLL_PREDIV,
    output logic PLL_FRAC,
    output logic LDO_SHUTDOWN,
    output logic [pccb_pkg::W_VSEL-1:0] LDO_VSEL,
    output logic AUX_CLOCK_PIN
);
    import pccb_pkg::*;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] clk_gating_reg; // Gate, source, halver, PLL power
    logic [7:0] den_hi_reg; // Denominator upper byte
    logic [7:0] den_lo_reg; // Denominator lower byte
    logic [7:0] num_hi_reg; // Numerator upper byte
    logic [7:0] num_lo_reg; // Numerator lower byte
    logic [7:0] pll_int_reg; // Multiplier, predivider, type
    logic [7:0] out_clk_reg; // Output clock code
    logic [7:0] ldo_reg; // Regulator controls
    logic lock_s1_reg, lock_s2_reg, lock_s3_reg; // Lock pin synchroniser
    logic lock_reg; // Filtered lock flag
    logic pll_clk_en_reg; // Gated PLL clock enable

    // ****************************************
    // Write decode
    // ****************************************
    logic main_gate; // Main clock gate bit
    logic hit_gating; // Address is gating register
    logic hit_pll_set; // Address is one of five PLL settings or the lock flag
    logic hit_param; // Address in parameter space
    logic in_bank; // Address held in this block
    logic gate_allows; // Main gate lockout passes
    logic param_allows; // Parameter lockout passes
    logic wr_ok; // Write will take effect

    assign main_gate = clk_gating_reg[BIT_MAIN_GATE];
    assign hit_gating = (REG_ADDR == ADDR_CLK_GATING);
    assign hit_pll_set = (REG_ADDR >= ADDR_PLL_DEN_HI) && (REG_ADDR <= ADDR_PLL_LOCK);
    assign hit_param = (REG_ADDR >= PARAM_BASE_ADDR);
    assign in_bank = (REG_ADDR <= ADDR_LDO);
    assign gate_allows = main_gate || hit_gating || hit_pll_set;
    assign param_allows = !(main_gate && !DSP_CLK_EN && hit_param);
    assign wr_ok = REG_WR_EN && gate_allows && param_allows;

    // Per-register write strobes
    logic we_gating, we_den_hi, we_den_lo, we_num_hi, we_num_lo;
    logic we_int, we_out, we_ldo;
    assign we_gating = wr_ok && hit_gating;
    assign we_den_hi = wr_ok && (REG_ADDR == ADDR_PLL_DEN_HI);
    assign we_den_lo = wr_ok && (REG_ADDR == ADDR_PLL_DEN_LO);
    assign we_num_hi = wr_ok && (REG_ADDR == ADDR_PLL_NUM_HI);
    assign we_num_lo = wr_ok && (REG_ADDR == ADDR_PLL_NUM_LO);
    assign we_int = wr_ok && (REG_ADDR == ADDR_PLL_INT);
    assign we_out = wr_ok && (REG_ADDR == ADDR_OUT_CLK);
    assign we_ldo = wr_ok && (REG_ADDR == ADDR_LDO);

    // ****************************************
    // Register writes
    // ****************************************
    // PLL settings are taken whenever addressed; keeping the PLL powered down
    // while writing them is software's job, so no check is made here.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            clk_gating_reg <= RESET_BYTE;
            den_hi_reg <= RESET_BYTE;
            den_lo_reg <= RESET_BYTE;
            num_hi_reg <= RESET_BYTE;
            num_lo_reg <= RESET_BYTE;
            pll_int_reg <= RESET_BYTE;
            out_clk_reg <= RESET_BYTE;
            ldo_reg <= RESET_BYTE;
        end else begin
            if (we_gating) begin
                clk_gating_reg <= REG_WDATA & CLK_GATING_MASK;
            end
            if (we_den_hi) begin
                den_hi_reg <= REG_WDATA;
            end
            if (we_den_lo) begin
                den_lo_reg <= REG_WDATA;
            end
            if (we_num_hi) begin
                num_hi_reg <= REG_WDATA;
            end
            if (we_num_lo) begin
                num_lo_reg <= REG_WDATA;
            end
            // integer register, bit 7 kept zero
            if (we_int) begin
                pll_int_reg <= {1'b0, REG_WDATA[6:0]};
            end
            if (we_out) begin
                out_clk_reg <= {5'h00, REG_WDATA[W_FREQ-1:0]};
            end
            if (we_ldo) begin
                ldo_reg <= {5'h00, REG_WDATA[2:0]};
            end
        end
    end

    // ****************************************
    // Lock flag input
    // ****************************************
    // Three-stage synchroniser; flag moves only when stages two and three agree
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            lock_s1_reg <= 1'b0;
            lock_s2_reg <= 1'b0;
            lock_s3_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            lock_s1_reg <= PLL_LOCK_IN;
            lock_s2_reg <= lock_s1_reg;
            lock_s3_reg <= lock_s2_reg;
            if (lock_s2_reg == lock_s3_reg) begin
                lock_reg <= lock_s3_reg;
            end
        end
    end

    // ****************************************
    // PLL clock gate and forwarding
    // ****************************************
    logic pll_clk_next; // PLL clock delivery condition
    // PLL clock needs power and gate
    assign pll_clk_next = clk_gating_reg[BIT_PLL_POWER] && main_gate;

    // Writes outside this bank that pass the gate and parameter lockouts go on to the rest of the device
    logic fwd_next;
    assign fwd_next = wr_ok && !in_bank;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pll_clk_en_reg <= 1'b0;
            REG_FWD_WE <= 1'b0;
            REG_FWD_ADDR <= 16'h0000;
            REG_FWD_WDATA <= 8'h00;
        end else begin
            pll_clk_en_reg <= pll_clk_next;
            REG_FWD_WE <= fwd_next;
            // Address and data held from the last forwarded write
            if (fwd_next) begin
                REG_FWD_ADDR <= REG_ADDR;
                REG_FWD_WDATA <= REG_WDATA;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [7:0] rd_mux; // Selected read byte
    assign rd_mux = (REG_ADDR == ADDR_CLK_GATING) ? clk_gating_reg :
                    (REG_ADDR == ADDR_PLL_DEN_HI) ? den_hi_reg :
                    (REG_ADDR == ADDR_PLL_DEN_LO) ? den_lo_reg :
                    (REG_ADDR == ADDR_PLL_NUM_HI) ? num_hi_reg :
                    (REG_ADDR == ADDR_PLL_NUM_LO) ? num_lo_reg :
                    (REG_ADDR == ADDR_PLL_INT) ? pll_int_reg :
                    (REG_ADDR == ADDR_PLL_LOCK) ? {7'h00, lock_reg} :
                    (REG_ADDR == ADDR_OUT_CLK) ? out_clk_reg :
                    (REG_ADDR == ADDR_LDO) ? ldo_reg : 8'h00;

    // Answer one cycle after the strobe; data holds until the next read
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
            REG_RD_VALID <= 1'b0;
        end else begin
            REG_RD_VALID <= REG_RD_EN;
            if (REG_RD_EN) begin
                REG_RDATA <= rd_mux;
            end
        end
    end

    // ****************************************
    // Aux clock generator
    // ****************************************
    pccb_aux_clock_pin_if co_if ();
    assign co_if.freq_code = out_clk_reg[W_FREQ-1:0];
    // any PDM output mode counts as on
    assign co_if.pdm_on = |PDM_OUTPUT_CONFIG_CFG;
    assign co_if.pin_clk_mode = PIN_CLK_MODE;

    pccb_aux_clock u_aux (
        .clock(CLOCK),
        .rst_n(RST_N),
        .co(co_if.gen)
    );

    // ****************************************
    // Output fields, all from flops, MCLK_HALVE through an inverter
    // ****************************************
    assign MAIN_CLK_EN = main_gate;
    assign MAIN_CLK_SRC = clk_gating_reg[BIT_SRC_SEL];
    assign MCLK_HALVE = !clk_gating_reg[BIT_HALVER];
    assign PLL_POWER = clk_gating_reg[BIT_PLL_POWER];
    assign PLL_CLK_EN = pll_clk_en_reg;
    assign PLL_DEN = {den_hi_reg, den_lo_reg};
    assign PLL_NUM = {num_hi_reg, num_lo_reg};
    assign PLL_MULT = pll_int_reg[BIT_MULT_LO +: W_MULT];
    assign PLL_FRAC = pll_int_reg[BIT_PLL_FRAC];
    assign PLL_PREDIV = pll_int_reg[BIT_PREDIV_LO +: W_PREDIV];
    assign LDO_SHUTDOWN = ldo_reg[BIT_LDO_SHUTDOWN];
    assign LDO_VSEL = ldo_reg[BIT_LDO_VSEL_LO +: W_VSEL];
    assign AUX_CLOCK_PIN = co_if.aux_clk;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_gated_ldo_write;
        REG_WR_EN && !main_gate && REG_ADDR == ADDR_LDO;
    endsequence
    chk_gate_blocks_write: assert property (
        s_gated_ldo_write |=> $stable(ldo_reg)) else $error("write passed closed gate");
    chk_param_lockout: assert property (
        (REG_WR_EN && main_gate && !DSP_CLK_EN && REG_ADDR >= PARAM_BASE_ADDR) |=> !REG_FWD_WE)
        else $error("parameter write not refused");
    chk_pll_clock_gate: assert property (
        PLL_CLK_EN == $past(clk_gating_reg[BIT_PLL_POWER] && clk_gating_reg[BIT_MAIN_GATE]))
        else $error("PLL clock gate wrong");
    chk_gate_bit_write: assert property (
        (REG_WR_EN && REG_ADDR == ADDR_CLK_GATING) |=> (MAIN_CLK_EN == $past(REG_WDATA[0])))
        else $error("main gate bit not written");
    chk_den_high_write: assert property (
        (REG_WR_EN && REG_ADDR == ADDR_PLL_DEN_HI) |=> (PLL_DEN[15:8] == $past(REG_WDATA)))
        else $error("denominator byte not written");
    chk_num_low_write: assert property (
        (REG_WR_EN && REG_ADDR == ADDR_PLL_NUM_LO) |=> (PLL_NUM[7:0] == $past(REG_WDATA)))
        else $error("numerator byte not written");
    sequence s_lock_read;
        REG_RD_EN && REG_ADDR == ADDR_PLL_LOCK;
    endsequence
    chk_lock_read_back: assert property (
        s_lock_read |=> REG_RD_VALID && REG_RDATA == {7'h00, $past(lock_reg)})
        else $error("lock flag read wrong");
    chk_lock_read_only: assert property (
        (REG_WR_EN && REG_ADDR == ADDR_PLL_LOCK && lock_s2_reg == lock_reg && lock_s3_reg == lock_reg)
        |=> $stable(lock_reg)) else $error("lock flag took a write");
    chk_ldo_write: assert property (
        (REG_WR_EN && main_gate && REG_ADDR == ADDR_LDO) |=> (LDO_SHUTDOWN == $past(REG_WDATA[2])))
        else $error("regulator bit not written");
endmodule

// file: test_pll_clock_config_bank.sv
// Self-checking bench for the clock configuration bank top module.
// Assumes pccb_pkg, the carrier interface and both design modules are compiled first.
module test_pll_clock_config_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import pccb_pkg::*;
    // ****************************************
    // Stimulus signals and bookkeeping
    // ****************************************
    logic CLOCK = 1'b0, RST_N = 1'b0, REG_WR_EN = 1'b0, REG_RD_EN = 1'b0; // Control
    logic [15:0] REG_ADDR = 16'h0000; // Address bus
    logic [7:0] REG_WDATA = 8'h00; // Write data
    logic PLL_LOCK_IN = 1'b0, DSP_CLK_EN = 1'b0, PIN_CLK_MODE = 1'b0; // Side inputs
    logic [W_PDM-1:0] PDM_OUTPUT_CONFIG_CFG = 2'h0; // PDM path off at start
    logic [7:0] REG_RDATA, REG_FWD_WDATA; // Read and forwarded data
    logic [15:0] REG_FWD_ADDR, PLL_DEN, PLL_NUM; // Wide outputs
    logic REG_RD_VALID, REG_FWD_WE, MAIN_CLK_EN, MAIN_CLK_SRC, MCLK_HALVE; // Flags
    logic PLL_POWER, PLL_CLK_EN, PLL_FRAC, LDO_SHUTDOWN, AUX_CLOCK_PIN; // Flags
    logic [W_MULT-1:0] PLL_MULT; // Multiplier field
    logic [W_PREDIV-1:0] PLL_PREDIV; // Predivider field
    logic [W_VSEL-1:0] LDO_VSEL; // Regulator voltage
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    logic [7:0] d[1:5]; // Random PLL setting bytes
    int err_total = 0, cmp_count = 0, fwd_hits = 0, h; // Counters
    int seed = 32'h4242; // Fixed seed keeps runs repeatable
    pccb_clock_bank DUT (.CLOCK(CLOCK), .RST_N(RST_N), .REG_WR_EN(REG_WR_EN), .REG_RD_EN(REG_RD_EN),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .PLL_LOCK_IN(PLL_LOCK_IN), .DSP_CLK_EN(DSP_CLK_EN),
        .PDM_OUTPUT_CONFIG_CFG(PDM_OUTPUT_CONFIG_CFG), .PIN_CLK_MODE(PIN_CLK_MODE), .REG_RDATA(REG_RDATA),
        .REG_RD_VALID(REG_RD_VALID), .REG_FWD_WE(REG_FWD_WE), .REG_FWD_ADDR(REG_FWD_ADDR),
        .REG_FWD_WDATA(REG_FWD_WDATA), .MAIN_CLK_EN(MAIN_CLK_EN), .MAIN_CLK_SRC(MAIN_CLK_SRC),
        .MCLK_HALVE(MCLK_HALVE), .PLL_POWER(PLL_POWER), .PLL_CLK_EN(PLL_CLK_EN), .PLL_DEN(PLL_DEN),
        .PLL_NUM(PLL_NUM), .PLL_MULT(PLL_MULT), .PLL_PREDIV(PLL_PREDIV), .PLL_FRAC(PLL_FRAC),
        .LDO_SHUTDOWN(LDO_SHUTDOWN), .LDO_VSEL(LDO_VSEL), .AUX_CLOCK_PIN(AUX_CLOCK_PIN));
    // ****************************************
    // Clock, watchdog and monitors
    // ****************************************
    // 50 MHz system clock
    initial begin
        forever #10 CLOCK = ~CLOCK;
    end
    // Cuts a hang short; bounded so the run always ends
    initial begin
        repeat (20000) @(posedge CLOCK);
        err_total++;
        wrap_up();
    end
    // Read results pair with the oldest expectation
    always @(posedge CLOCK) begin
        if (REG_RD_VALID === 1'b1) begin
            // A read answer with no note waiting is itself a mismatch
            if (exp_q.size() == 0) begin
                check(16'(exp_q.size()), 16'h0001);
            end else begin
                check(REG_RDATA, exp_q.pop_front());
            end
        end
    end
    // Counts forwarded writes; blocked ones never show here
    always @(posedge CLOCK) begin
        if (REG_FWD_WE === 1'b1) fwd_hits++;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge CLOCK);
        REG_WR_EN <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge CLOCK);
        REG_WR_EN <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        @(posedge CLOCK);
        REG_RD_EN <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RD_EN <= 1'b0;
    endtask
    // Write into forward space and count what came out
    task automatic fwd(input logic [15:0] a, input logic [7:0] v, input int n);
        h = fwd_hits;
        wr(a, v);
        repeat (2) @(posedge CLOCK);
        #1;
        check(16'(fwd_hits - h), 16'(n));
    endtask
    // Toggles of the aux pin over 64 cycles after it settles
    task automatic aux(input logic [2:0] code, input logic [1:0] pdm, input logic pin, input int n);
        int cnt;
        logic prev;
        wr(ADDR_OUT_CLK, {5'h00, code});
        PDM_OUTPUT_CONFIG_CFG <= pdm;
        PIN_CLK_MODE <= pin;
        repeat (40) @(posedge CLOCK);
        #1;
        cnt = 0;
        prev = AUX_CLOCK_PIN;
        repeat (64) begin
            @(posedge CLOCK);
            #1;
            if (AUX_CLOCK_PIN !== prev) cnt++;
            prev = AUX_CLOCK_PIN;
        end
        check(16'(cnt), 16'(n));
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        for (int a = 0; a <= 8; a++) rd(16'(a), 8'h00);
        check(MCLK_HALVE, 1'b1);
        wr(ADDR_LDO, 8'h04);
        rd(ADDR_LDO, 8'h00);
        // PLL settings written while PLL power is off
        for (int i = 1; i <= 5; i++) begin
            d[i] = 8'($random(seed));
            wr(16'(i), d[i]);
            // Integer register has no bit 7, so it reads back zero
            rd(16'(i), (i == 5) ? (d[i] & 8'h7f) : d[i]);
        end
        check(PLL_DEN, {d[1], d[2]});
        check(PLL_NUM, {d[3], d[4]});
        check(PLL_MULT, d[5][6:3]);
        check(PLL_PREDIV, d[5][2:1]);
        check(PLL_FRAC, d[5][0]);
        // lock flag read only, follows the pin
        wr(ADDR_PLL_LOCK, 8'hff);
        rd(ADDR_PLL_LOCK, 8'h00);
        PLL_LOCK_IN <= 1'b1;
        repeat (6) @(posedge CLOCK);
        rd(ADDR_PLL_LOCK, 8'h01);
        // gate and PLL source set only after lock
        wr(ADDR_CLK_GATING, 8'hff);
        rd(ADDR_CLK_GATING, CLK_GATING_MASK);
        check({MAIN_CLK_EN, MAIN_CLK_SRC, MCLK_HALVE, PLL_POWER}, 4'hd);
        repeat (2) @(posedge CLOCK);
        #1;
        check(PLL_CLK_EN, 1'b1);
        wr(ADDR_LDO, 8'h05);
        rd(ADDR_LDO, 8'h05);
        check({LDO_SHUTDOWN, LDO_VSEL}, 3'h5);
        rd(16'h0020, 8'h00);
        // parameters locked until DSP clock on
        fwd(param_addr(16'h0000), 8'h5a, 0);
        fwd(16'h3fff, 8'h11, 1);
        DSP_CLK_EN <= 1'b1;
        fwd(ADDR_PARAM_BASE, 8'ha5, 1);
        check(REG_FWD_ADDR, ADDR_PARAM_BASE);
        check(REG_FWD_WDATA, 8'ha5);
        aux(FREQ_DOUBLE, 2'h0, 1'b1, 64);
        aux(FREQ_PASS, 2'h0, 1'b1, 32);
        aux(FREQ_HALF, 2'h0, 1'b1, 16);
        aux(FREQ_QUARTER, 2'h0, 1'b1, 8);
        aux(FREQ_EIGHTH, 2'h0, 1'b1, 4);
        aux(FREQ_OFF, 2'h0, 1'b1, 0);
        aux(FREQ_DOUBLE, 2'h2, 1'b1, 0);
        aux(FREQ_PASS, 2'h1, 1'b1, 0);
        aux(FREQ_HALF, 2'h3, 1'b1, 16);
        aux(FREQ_HALF, 2'h0, 1'b0, 0);
        // gate off stops PLL clock and forwarding
        wr(ADDR_CLK_GATING, 8'h80);
        repeat (2) @(posedge CLOCK);
        #1;
        check(PLL_CLK_EN, 1'b0);
        fwd(16'h0010, 8'h33, 0);
        repeat (3) @(posedge CLOCK);
        check(16'(exp_q.size()), 16'h0000);
        wrap_up();
    end
    // Parameter space start, offset kept explicit
    function automatic logic [15:0] param_addr(input logic [15:0] off);
        return ADDR_PARAM_BASE + off;
    endfunction
endmodule
